/* core/serial_eeprom_slave_engine.sv */
// What this block does
// - START: data falls, clock high, unless busy
// - STOP: data rises, clock high; standby
// - Sample data bits on clock rising edge
// - Ninth pulse: receiver pulls data low
// - Select: type, two straps, top address bit
// - Select bit 0: one reads, zero writes
// - Match acknowledges; mismatch stays silent, standby
// - Write: acknowledge select and address byte
// - Write starts only on tenth-slot STOP
// - After write, counter points past last byte
// - Busy write cycle: silent, ignores everything
// - Protected: data bytes refused, nothing written
// - Page write: up to sixteen bytes buffered
// - Page overflow wraps to page start
// - Reads ignore protect; counter advances per byte
// - Master no-acknowledge ends read, standby
// - Random read: dummy write, repeated START
// - Current read uses and bumps counter
// - Acknowledged read bytes continue sequentially
// - Counter wraps to zero; five-lead holds
// - Protect low or floating means writable
// - Floating straps compare as zero
`timescale 1ns/1ps
`default_nettype none
module serial_eeprom_slave_engine
  import eeprom_pkg::*;
#(
  parameter int         WRITE_CYCLES = WRITE_CYC_DEF,
  parameter logic [3:0] TYPE_ID      = TYPE_ID_DEF
) (
  input  wire logic  clk_sys_i,
  input  wire logic  rst_n_i,
  input  wire logic  scl_clk_i,
  input  wire logic  scl_i,
  input  wire logic  sda_i,
  output logic       sda_o,
  output logic       sda_oe_o,
  input  wire logic  chip_strap_low_i,
  input  wire logic  chip_strap_high_i,
  input  wire logic  write_protect_input_i,
  input  wire logic  five_lead_package_variant_i,
  output logic       busy_o
);
  localparam int TW = $clog2(WRITE_CYCLES + 1);
  localparam logic [TW-1:0] TW_LAST = TW'(WRITE_CYCLES - 1);

  typedef struct packed {
    eng_state_t                     st;
    logic [3:0]                     cnt;
    logic [7:0]                     sh;
    logic                           ack;
    logic [ADDR_W-1:0]              addr;
    logic [PAGE_BYTES-1:0][7:0]     pbuf;
    logic [PAGE_BYTES-1:0]          pmask;
    logic [PAGE_W:0]                cidx;
    logic [TW-1:0]                  tmr;
    logic                           sda_oe;
    logic                           sda_lvl;
    logic                           busy;
    logic                           wr_en;
    logic [ADDR_W-1:0]              wr_addr;
    logic [7:0]                     wr_data;
    logic                           scl_s1;
    logic                           scl_s2;
    logic                           scl_s3;
    logic                           sda_s1;
    logic                           sda_s2;
    logic                           sda_s3;
    logic                           tog_s1;
    logic                           tog_s2;
    logic                           tog_s3;
    logic [3:0]                     pin_s1;
    logic [3:0]                     pin_s2;
  } eng_t;

  eng_t q;
  eng_t d;

  link_bit_if lnk ();
  mem_port_if mem ();

  link_capture u_cap (
    .scl_clk_i (scl_clk_i),
    .rst_n_i   (rst_n_i),
    .sda_i     (sda_i),
    .lnk       (lnk.src)
  );

  eeprom_array #(
    .DEPTH (MEM_DEPTH)
  ) u_arr (
    .clk_sys_i (clk_sys_i),
    .mem       (mem.arr)
  );

  function automatic logic sel_match(input logic [7:0] b, input logic hi,
                                     input logic lo, input logic five);
    logic eh;
    logic el;
    eh = hi & ~five;
    el = lo & ~five;
    sel_match = (b[TYPE_MSB:TYPE_LSB] == TYPE_ID) && (b[STRAP_HI_BIT] == eh)
                && (b[STRAP_LO_BIT] == el);
  endfunction

  function automatic logic [ADDR_W-1:0] addr_next(input logic [ADDR_W-1:0] a,
                                                  input logic five);
    if (five && (a == LAST_ADDR)) begin
      addr_next = a;
    end else begin
      addr_next = a + 9'h001;
    end
  endfunction

  logic                  rise;
  logic                  fall;
  logic                  start;
  logic                  stop;
  logic                  wp;
  logic                  s_hi;
  logic                  s_lo;
  logic                  five;
  logic [7:0]            nb;
  logic [3:0]            k;
  logic [PAGE_W-1:0]     pix;

  always_comb begin
    d = q;
    d.scl_s1 = scl_i;
    d.scl_s2 = q.scl_s1;
    d.scl_s3 = q.scl_s2;
    d.sda_s1 = sda_i;
    d.sda_s2 = q.sda_s1;
    d.sda_s3 = q.sda_s2;
    d.tog_s1 = lnk.bit_tog;
    d.tog_s2 = q.tog_s1;
    d.tog_s3 = q.tog_s2;
    d.pin_s1 = {five_lead_package_variant_i, chip_strap_high_i,
                chip_strap_low_i, write_protect_input_i};
    d.pin_s2 = q.pin_s1;
    d.wr_en  = 1'b0;
    d.sda_lvl = 1'b0;
    wp    = q.pin_s2[0];
    s_lo  = q.pin_s2[1];
    s_hi  = q.pin_s2[2];
    five  = q.pin_s2[3];
    rise  = q.tog_s2 ^ q.tog_s3;
    fall  = q.scl_s3 & ~q.scl_s2;
    start = q.scl_s2 & q.scl_s3 & q.sda_s3 & ~q.sda_s2;
    stop  = q.scl_s2 & q.scl_s3 & ~q.sda_s3 & q.sda_s2;
    nb    = {q.sh[6:0], lnk.bit_val};
    k     = LAST_BIT - q.cnt;
    pix   = q.cidx[PAGE_W-1:0];

    if (q.st == ST_BUSY) begin
      d.sda_oe = 1'b0;
      if (!q.cidx[PAGE_W]) begin
        d.cidx = q.cidx + 5'h01;
        if (q.pmask[pix]) begin
          d.wr_en   = 1'b1;
          d.wr_addr = {q.addr[ADDR_W-1:PAGE_W], pix};
          d.wr_data = q.pbuf[pix];
        end
      end
      if (q.tmr >= TW_LAST && q.cidx[PAGE_W]) begin
        d.st   = ST_IDLE;
        d.busy = 1'b0;
      end else begin
        d.tmr = q.tmr + TW'(1);
      end
    end else if (start) begin
      d.st     = ST_SEL;
      d.cnt    = 4'h0;
      d.ack    = 1'b0;
      d.sda_oe = 1'b0;
    end else if (stop) begin
      d.sda_oe = 1'b0;
      if (q.st == ST_WDATA && q.cnt == STOP_SLOT && q.pmask != '0) begin
        d.st   = ST_BUSY;
        d.busy = 1'b1;
        d.cidx = '0;
        d.tmr  = '0;
      end else begin
        d.st = ST_IDLE;
      end
    end else if (rise && q.st == ST_RDATA) begin
      if (q.cnt != ACK_SLOT) begin
        d.cnt = q.cnt + 4'h1;
        if (q.cnt == LAST_BIT) begin
          d.addr = addr_next(q.addr, five);
        end
      end else begin
        d.cnt = 4'h0;
        if (lnk.bit_val) begin
          d.st = ST_IDLE;
        end
      end
    end else if (rise && q.st != ST_IDLE) begin
      if (q.cnt != ACK_SLOT) begin
        d.sh  = nb;
        d.cnt = q.cnt + 4'h1;
        if (q.cnt == LAST_BIT) begin
          case (q.st)
            ST_SEL:   d.ack = sel_match(nb, s_hi, s_lo, five);
            ST_ADDR:  d.ack = 1'b1;
            ST_WDATA: d.ack = ~wp;
            default:  d.ack = 1'b0;
          endcase
        end
      end else begin
        d.cnt = 4'h0;
        case (q.st)
          ST_SEL: begin
            if (!q.ack) begin
              d.st = ST_IDLE;
            end else begin
              d.addr[ADDR_W-1] = q.sh[TOP_ADDR_BIT];
              d.st = q.sh[RW_BIT] ? ST_RDATA : ST_ADDR;
            end
          end
          ST_ADDR: begin
            d.addr[7:0] = q.sh;
            d.pmask     = '0;
            d.st        = ST_WDATA;
          end
          ST_WDATA: begin
            if (q.ack) begin
              d.pbuf[q.addr[PAGE_W-1:0]]  = q.sh;
              d.pmask[q.addr[PAGE_W-1:0]] = 1'b1;
              d.addr[PAGE_W-1:0] = q.addr[PAGE_W-1:0] + 4'h1;
            end
          end
          default: d.st = ST_IDLE;
        endcase
      end
    end else if (fall && q.st == ST_RDATA) begin
      if (q.cnt == 4'h0) begin
        d.sh     = mem.rd_data;
        d.sda_oe = ~mem.rd_data[7];
      end else if (q.cnt != ACK_SLOT) begin
        d.sda_oe = ~q.sh[k[2:0]];
      end else begin
        d.sda_oe = 1'b0;
      end
    end else if (fall && q.st != ST_IDLE) begin
      d.sda_oe = (q.cnt == ACK_SLOT) & q.ack;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign mem.rd_addr = q.addr;
  assign mem.wr_en   = q.wr_en;
  assign mem.wr_addr = q.wr_addr;
  assign mem.wr_data = q.wr_data;

  assign sda_o    = q.sda_lvl;
  assign sda_oe_o = q.sda_oe;
  assign busy_o   = q.busy;
endmodule
`default_nettype wire

/* core/eeprom_pkg.sv */
package eeprom_pkg;
  localparam int          ADDR_W        = 9;
  localparam int          PAGE_W        = 4;
  localparam int          PAGE_BYTES    = 16;
  localparam int          MEM_DEPTH     = 512;
  localparam logic [3:0]  ACK_SLOT      = 4'h8;
  localparam logic [3:0]  LAST_BIT      = 4'h7;
  localparam logic [3:0]  STOP_SLOT     = 4'h1;
  localparam int          TYPE_MSB      = 7;
  localparam int          TYPE_LSB      = 4;
  localparam int          STRAP_HI_BIT  = 3;
  localparam int          STRAP_LO_BIT  = 2;
  localparam int          TOP_ADDR_BIT  = 1;
  localparam int          RW_BIT        = 0;
  localparam logic [8:0]  LAST_ADDR     = 9'h1ff;
  // Arbitrary type code, chosen freely
  localparam logic [3:0]  TYPE_ID_DEF   = 4'h5;
  localparam int          CLK_PERIOD_NS = 25;
  // Plain default; set the real write time per part
  localparam int          WRITE_TIME_NS = 1000000;
  localparam int          WRITE_CYC_DEF = WRITE_TIME_NS / CLK_PERIOD_NS;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_SEL,
    ST_ADDR,
    ST_WDATA,
    ST_RDATA,
    ST_BUSY
  } eng_state_t;
endpackage

/* core/eeprom_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface link_bit_if;
  logic bit_val;
  logic bit_tog;
  modport src (output bit_val, output bit_tog);
  modport dst (input bit_val, input bit_tog);
endinterface

interface mem_port_if;
  logic [8:0] rd_addr;
  logic [7:0] rd_data;
  logic       wr_en;
  logic [8:0] wr_addr;
  logic [7:0] wr_data;
  modport eng (output rd_addr, input rd_data, output wr_en, output wr_addr, output wr_data);
  modport arr (input rd_addr, output rd_data, input wr_en, input wr_addr, input wr_data);
endinterface
`default_nettype wire

/* core/link_capture.sv */
`timescale 1ns/1ps
`default_nettype none
module link_capture (
  input  wire logic  scl_clk_i,
  input  wire logic  rst_n_i,
  input  wire logic  sda_i,
  link_bit_if.src    lnk
);
  typedef struct packed {
    logic bit_val;
    logic tog;
  } cap_t;

  cap_t q;
  cap_t d;

  // Serial clock may stand still, so this domain clears without an edge
  always_comb begin
    d = q;
    d.bit_val = sda_i;
    d.tog     = ~q.tog;
  end

  always_ff @(posedge scl_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign lnk.bit_val = q.bit_val;
  assign lnk.bit_tog = q.tog;
endmodule
`default_nettype wire

/* core/eeprom_array.sv */
`timescale 1ns/1ps
`default_nettype none
module eeprom_array #(
  parameter int DEPTH = 512
) (
  input  wire logic  clk_sys_i,
  mem_port_if.arr    mem
);
  // Non-volatile contents: deliberately not cleared by reset
  logic [7:0] cells [0:DEPTH-1];

  always_ff @(posedge clk_sys_i) begin
    if (mem.wr_en) begin
      cells[mem.wr_addr] <= mem.wr_data;
    end
  end

  assign mem.rd_data = cells[mem.rd_addr];
endmodule
`default_nettype wire

/* dv/serial_eeprom_slave_engine_checker.sv */
`timescale 1ns/1ps
`default_nettype none
module serial_eeprom_slave_engine_checker #(
  parameter int WRITE_CYCLES = 40
) (
  input  wire logic clk_sys_i,
  input  wire logic rst_n_i,
  input  wire logic scl_i,
  input  wire logic sda_i,
  input  wire logic sda_o,
  input  wire logic sda_oe_o,
  input  wire logic write_protect_input_i,
  input  wire logic busy_o
);
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!rst_n_i);
  // Busy length counter; a slack of four covers the STOP sync delay
  logic [31:0] cnt_q;
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i || !busy_o) begin
      cnt_q <= 32'h0;
    end else begin
      cnt_q <= cnt_q + 32'h1;
    end
  end
  a_sda_low_level: assert property (sda_oe_o |-> (sda_o == 1'b0 && !sda_i)) else $error("sda not pulled low");
  a_oe_scl_low: assert property ($changed(sda_oe_o) |-> !scl_i) else $error("sda moved scl high");
  a_oe_hold: assert property ($rose(sda_oe_o) |=> sda_oe_o[*2]) else $error("ack too short");
  a_busy_silent: assert property (busy_o |-> !sda_oe_o) else $error("drive while busy");
  a_busy_min: assert property ($rose(busy_o) |=> busy_o[*8]) else $error("busy too short");
  a_busy_len: assert property ($fell(busy_o) |-> cnt_q >= WRITE_CYCLES - 4 && cnt_q <= WRITE_CYCLES)
    else $error("write time wrong");
  a_busy_on_stop: assert property ($rose(busy_o) |-> scl_i && sda_i) else $error("write not at stop");
  a_wp_no_write: assert property ($rose(busy_o) |-> !$past(write_protect_input_i, 4))
    else $error("write while protected");
  c_write: cover property ($rose(busy_o));
  c_drive: cover property ($rose(sda_oe_o));
  c_done: cover property ($fell(busy_o));
endmodule
bind serial_eeprom_slave_engine serial_eeprom_slave_engine_checker #(
  .WRITE_CYCLES(WRITE_CYCLES)
) u_chk (.clk_sys_i, .rst_n_i, .scl_i, .sda_i, .sda_o, .sda_oe_o, .write_protect_input_i, .busy_o);
`default_nettype wire

/* dv/eeprom_bus_master.sv */
`timescale 1ns/1ps
`default_nettype none
module eeprom_bus_master (
  input  wire logic lnk_clk_i,
  input  wire logic sda_i,
  output var  logic scl_o,
  output var  logic sda_oe_o
);
  initial begin
    scl_o = 1'b1;
    sda_oe_o = 1'b0;
  end
  // Phases of six ticks keep each scl level above 150 ns
  task automatic tick(input int n);
    repeat (n) @(posedge lnk_clk_i);
  endtask
  // Start from idle or repeated
  task automatic start();
    sda_oe_o <= 1'b0;
    tick(6);
    scl_o <= 1'b1;
    tick(6);
    sda_oe_o <= 1'b1;
    tick(6);
    scl_o <= 1'b0;
    tick(1);
  endtask
  // data moves one tick after scl fall
  task automatic xbyte(input logic [7:0] d, input logic ack_i,
                       output logic [7:0] q, output logic ack_o);
    logic [8:0] v;
    v = {d, ack_i};
    for (int i = 8; i >= 0; i--) begin
      sda_oe_o <= ~v[i];
      tick(6);
      scl_o <= 1'b1;
      tick(6);
      if (i > 0) begin
        q[i-1] = sda_i;
      end else begin
        ack_o = sda_i;
      end
      scl_o <= 1'b0;
      tick(1);
    end
  endtask
  task automatic stop();
    sda_oe_o <= 1'b1;
    tick(6);
    scl_o <= 1'b1;
    tick(6);
    sda_oe_o <= 1'b0;
    tick(6);
  endtask
endmodule
`default_nettype wire

/* dv/tb_serial_eeprom_slave_engine.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_serial_eeprom_slave_engine;
  // Type code is arbitrary
  localparam logic [3:0] TID = 4'h9;
  logic clk_sys_i, rst_n_i, lnk_clk, m_oe, d_o, d_oe, busy, s_lo, s_hi, wp, five;
  wire  scl;
  wire  sda;
  int   error_cnt, num_checks;
  // Pull-up wire: low when anyone pulls
  assign sda = (m_oe || (d_oe && !d_o)) ? 1'b0 : 1'b1;
  always #12.5 clk_sys_i = ~clk_sys_i;
  always #15 lnk_clk = ~lnk_clk;
  eeprom_bus_master m (.lnk_clk_i(lnk_clk), .sda_i(sda), .scl_o(scl), .sda_oe_o(m_oe));
  serial_eeprom_slave_engine #(.WRITE_CYCLES(400), .TYPE_ID(TID)) uut (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .scl_clk_i(scl), .scl_i(scl), .sda_i(sda),
    .sda_o(d_o), .sda_oe_o(d_oe), .chip_strap_low_i(s_lo), .chip_strap_high_i(s_hi),
    .write_protect_input_i(wp), .five_lead_package_variant_i(five), .busy_o(busy));
  task automatic end_sim();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
    num_checks++;
    if (s !== e) begin
      $display("wrong value %s expected %h seen %h", n, e, s);
      error_cnt++;
    end
  endtask
  function automatic logic [7:0] sel(input logic [1:0] s, input logic a8, input logic r);
    return {TID, s, a8, r};
  endfunction
  task automatic wr(input logic [7:0] d, input logic e);
    logic [7:0] q;
    logic       a;
    m.xbyte(d, 1'b1, q, a);
    chk("ack", {7'h0, e}, {7'h0, a});
  endtask
  task automatic rd(input logic mack, input logic [7:0] e);
    logic [7:0] q;
    logic       a;
    m.xbyte(8'hff, mack, q, a);
    chk("rdata", e, q);
  endtask
  // Poll until acknowledged; first try must be refused
  task automatic poll(input logic [7:0] s);
    logic [7:0] q;
    logic       a;
    int         n;
    a = 1'b1;
    n = 0;
    while (a !== 1'b0 && n < 50) begin
      m.start();
      m.xbyte(s, 1'b1, q, a);
      n++;
    end
    chk("poll ack", 8'h0, {7'h0, a});
    chk("refused", 8'h1, {7'h0, n > 1});
    if (a !== 1'b0) begin
      end_sim();
    end
  endtask
  initial begin
    clk_sys_i = 1'b0;
    lnk_clk = 1'b0;
    rst_n_i = 1'b0;
    {s_lo, s_hi, wp, five} = 4'h4;
    repeat (12) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    repeat (4) @(posedge clk_sys_i);
    m.start();
    wr(sel(2'b00, 1'b0, 1'b0), 1'b1);
    m.stop();
    m.start();
    wr(sel(2'b10, 1'b0, 1'b0), 1'b0);
    wr(8'h00, 1'b0);
    wr(8'hd0, 1'b0);
    m.stop();
    poll(sel(2'b10, 1'b0, 1'b0));
    m.stop();
    repeat (20) @(posedge clk_sys_i);
    chk("busy", 8'h0, {7'h0, busy});
    m.start();
    wr(sel(2'b10, 1'b1, 1'b0), 1'b0);
    wr(8'hf0, 1'b0);
    for (int i = 0; i < 17; i++) begin
      wr(8'h30 + 8'(i), 1'b0);
    end
    m.stop();
    poll(sel(2'b10, 1'b1, 1'b1));
    rd(1'b1, 8'h31);
    m.stop();
    m.start();
    wr(sel(2'b10, 1'b1, 1'b0), 1'b0);
    wr(8'hff, 1'b0);
    m.start();
    wr(sel(2'b10, 1'b1, 1'b1), 1'b0);
    rd(1'b0, 8'h3f);
    rd(1'b1, 8'hd0);
    m.stop();
    @(posedge clk_sys_i);
    wp <= 1'b1;
    five <= 1'b1;
    repeat (4) @(posedge clk_sys_i);
    m.start();
    wr(sel(2'b00, 1'b0, 1'b0), 1'b0);
    wr(8'h00, 1'b0);
    wr(8'h55, 1'b1);
    m.stop();
    repeat (20) @(posedge clk_sys_i);
    chk("busy", 8'h0, {7'h0, busy});
    m.start();
    wr(sel(2'b00, 1'b0, 1'b0), 1'b0);
    wr(8'h00, 1'b0);
    m.start();
    wr(sel(2'b00, 1'b0, 1'b1), 1'b0);
    rd(1'b1, 8'hd0);
    m.stop();
    m.start();
    wr(sel(2'b00, 1'b1, 1'b0), 1'b0);
    wr(8'hf0, 1'b0);
    m.start();
    wr(sel(2'b00, 1'b1, 1'b1), 1'b0);
    rd(1'b1, 8'h40);
    m.stop();
    m.start();
    wr(sel(2'b00, 1'b1, 1'b0), 1'b0);
    wr(8'hff, 1'b0);
    m.start();
    wr(sel(2'b00, 1'b1, 1'b1), 1'b0);
    rd(1'b0, 8'h3f);
    rd(1'b1, 8'h3f);
    m.stop();
    end_sim();
  end
endmodule
`default_nettype wire
